// File: dv/acx_cmd_exec_props.sv
// Checker for the command executor: reply, parameter strobe and register rules.
// Assumes it is bound onto acx_cmd_exec, one clock, active-low async reset.
module acx_cmd_exec_props
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst_b,
    // Watched ports
    input wire logic        byte_ready,
    input wire logic        accu_load,
    input wire logic [31:0] accu_load_value,
    input wire logic        par_wr,
    input wire logic [31:0] par_value,
    input wire logic        reply_valid,
    input wire logic        reply_ready,
    input wire logic [7:0]  reply_status,
    input wire logic [31:0] accu,
    input wire logic [31:0] x_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // Reply handshake; no new frame is taken while a reply waits
    AST_STATUS_OK: assert property (reply_valid |-> reply_status == 8'h64 && !byte_ready)
        else $error("reply status wrong or bytes taken during reply");
    AST_REPLY_HOLD: assert property (reply_valid && !reply_ready |=> reply_valid)
        else $error("reply withdrawn before taken");
    AST_REPLY_ONCE: assert property (reply_valid && reply_ready |=> !reply_valid)
        else $error("reply given twice");
    // Parameter strobe carries the accumulator of the executing cycle
    AST_PAR_PULSE: assert property (par_wr |=> !par_wr)
        else $error("parameter strobe longer than one cycle");
    AST_PAR_VALUE: assert property (par_wr |-> par_value == $past(accu))
        else $error("parameter value differs from accumulator");
    // Registers only move by a load or by execution
    AST_ACCU_LOAD: assert property (accu_load && byte_ready |=> accu == $past(accu_load_value))
        else $error("accumulator load lost");
    AST_ACCU_QUIET: assert property (!accu_load && (byte_ready || reply_valid) |=> $stable(accu))
        else $error("accumulator changed outside execution");
    AST_X_ONLY_EXEC: assert property (!$stable(x_reg) |-> !$past(byte_ready) && !$past(reply_valid))
        else $error("second operand changed outside execution");

    // Main scenarios reached
    COV_PAR: cover property (par_wr);
    COV_REPLY: cover property (reply_valid && reply_ready);
    COV_LOAD: cover property (accu_load && byte_ready);
endmodule

bind acx_cmd_exec acx_cmd_exec_props acx_cmd_exec_props_inst (.core_clk, .rst_b, .byte_ready, .accu_load,
    .accu_load_value, .par_wr, .par_value, .reply_valid, .reply_ready, .reply_status, .accu, .x_reg);

// File: dv/acx_host_model.sv
// Host model: sends nine-byte frames byte by byte and takes replies.
// Assumes its task is started just after a rising clock edge.
module acx_host_model
(
    // Clock and pacing
    input  wire logic       core_clk,
    input  wire logic       slow,
    // Frame byte stream
    input  wire logic       byte_ready,
    output logic            byte_valid,
    output logic [7:0]      byte_data,
    // Reply
    output logic            reply_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pace_q = 2'h0;

    initial
    begin
        byte_valid = 1'b0;
        byte_data = 8'hA5;
    end

    // A slow host takes a reply one cycle in four, so the reply must wait
    always @(posedge core_clk)
    begin
        pace_q <= pace_q + 2'h1;
        reply_ready <= #2 !slow || pace_q == 2'h3;
    end

    // Held until taken; idle data is inverted so stale bytes never look valid
    task automatic send(input logic [7:0] f [9]);
        for (int i = 0; i < 9; i++)
        begin
            byte_valid = 1'b1;
            byte_data = f[i];
            do @(negedge core_clk); while (!byte_ready);
            @(posedge core_clk);
            #2;
            if (slow || i == 8)
            begin
                byte_valid = 1'b0;
                byte_data = ~f[i];
            end
            if (slow && i < 8)
                @(posedge core_clk) #2;
        end
    endtask
endmodule

// File: dv/tb.sv
// Self-checking bench for the command executor against an integer model.
// Assumes acx_pkg, the executor, host model and checker compiled first.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import acx_pkg::*;
    logic        core_clk, rst_b, byte_valid, byte_ready, direct_mode, accu_load, slow;
    logic        par_wr, par_is_global, reply_valid, reply_ready;
    logic [7:0]  byte_data, par_index, par_bank, reply_addr, reply_status, reply_instr;
    logic [31:0] accu_load_value, par_value, reply_value, accu, x_reg;
    logic [48:0] par_q [$];
    int          error_cnt, num_checks, cyc, m_acc, m_x;
    integer      seed = 32'h0735ABBE;

    acx_cmd_exec acx_cmd_exec_inst (.core_clk, .rst_b, .byte_valid, .byte_data, .byte_ready, .own_addr(8'h01),
        .direct_mode, .accu_load, .accu_load_value, .par_wr, .par_is_global, .par_index, .par_bank, .par_value,
        .reply_valid, .reply_ready, .reply_addr, .reply_status, .reply_instr, .reply_value, .accu, .x_reg);
    acx_host_model acx_host_model_inst (.core_clk, .slow, .byte_ready, .byte_valid, .byte_data, .reply_ready);

    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Cycle ceiling and capture of every parameter strobe
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (par_wr === 1'b1)
            par_q.push_back({par_is_global, par_index, par_bank, par_value});
        if (cyc == 20000)
        begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic chk(input string name, input logic [48:0] exp, input logic [48:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic load_accu(input int v);
        accu_load = 1'b1;
        accu_load_value = v;
        @(posedge core_clk) #2;
        accu_load = 1'b0;
        accu_load_value = $random(seed);
        m_acc = v;
    endtask

    // Integer model; division by zero leaves the accumulator alone
    task automatic apply(input logic [7:0] typ);
        case (typ)
            8'h00: m_acc += m_x;
            8'h01: m_acc -= m_x;
            8'h02: m_acc *= m_x;
            8'h03: if (m_x != 0) m_acc /= m_x;
            8'h04: if (m_x != 0) m_acc %= m_x;
            8'h05: m_acc &= m_x;
            8'h06: m_acc |= m_x;
            8'h07: m_acc ^= m_x;
            8'h08: m_acc = ~m_x;
            8'h09: m_x = m_acc;
            8'h0A: {m_acc, m_x} = {m_x, m_acc};
            default: ;
        endcase
    endtask

    task automatic cmd(input logic [7:0] addr, input logic [7:0] ins, input logic [7:0] typ, input logic [7:0] bad);
        logic [7:0] f [9];
        int n = 0;
        logic run;
        f[0] = addr;
        f[1] = ins;
        f[2] = typ;
        f[8] = bad;
        for (int i = 3; i < 8; i++)
            f[i] = 8'($random(seed));
        for (int i = 0; i < 8; i++)
            f[8] += f[i];
        run = addr == 8'h01 && bad == 8'h00 && ins inside {8'h21, 8'h22, 8'h23};
        slow = 1'($random(seed));
        acx_host_model_inst.send(f);
        if (run && ins == 8'h21)
            apply(typ);
        if (run && direct_mode)
        begin
            do @(negedge core_clk); while (!(reply_valid && reply_ready) && ++n < 200);
            chk("reply", {ACX_STATUS_OK, addr, ins}, {reply_status, reply_addr, reply_instr});
            chk("reply value", 49'h0, 49'(reply_value));
        end
        else
        begin
            // Watch until back in receive, so a late or stray reply is caught
            do @(negedge core_clk); while (byte_ready !== 1'b1 && reply_valid !== 1'b1 && ++n < 200);
            chk("no reply", 49'h0, 49'(reply_valid));
        end
        do @(negedge core_clk); while (byte_ready !== 1'b1 && ++n < 200);
        chk("wait", 49'h0, 49'(n >= 200));
        @(posedge core_clk) #2;
        chk("accu", $unsigned(m_acc), accu);
        chk("x_reg", $unsigned(m_x), x_reg);
        if (run && ins != 8'h21)
            chk("param", {ins == 8'h23, typ, f[3], $unsigned(m_acc)}, par_q.pop_front());
        chk("param count", 49'h0, 49'(par_q.size()));
    endtask

    initial
    begin
        rst_b = 1'b0;
        direct_mode = 1'b1;
        accu_load = 1'b0;
        accu_load_value = 32'h0;
        slow = 1'b0;
        repeat (16) @(posedge core_clk);
        #2;
        rst_b = 1'b1;
        chk("reset", 49'h0, 49'(accu | x_reg));
        // Every type code, unknown one too; first round divides by zero
        for (int r = 0; r < 3; r++)
            for (int op = 0; op < 12; op++)
            begin
                load_accu(r == 0 ? 0 : $random(seed));
                cmd(8'h01, 8'h21, 8'h09, 8'h00);
                load_accu($random(seed));
                cmd(8'h01, 8'h21, 8'(op), 8'h00);
            end
        for (int i = 0; i < 4; i++)
        begin
            load_accu($random(seed));
            cmd(8'h01, 8'h22 + 8'(i[0]), 8'($random(seed)), 8'h00);
        end
        // Dropped frames: bad checksum, foreign address, foreign instruction
        cmd(8'h01, 8'h21, 8'h00, 8'h01);
        cmd(8'h02, 8'h22, 8'h00, 8'h00);
        cmd(8'h01, 8'h24, 8'h00, 8'h00);
        // Without direct mode commands still execute, silently
        direct_mode = 1'b0;
        cmd(8'h01, 8'h21, 8'h03, 8'h00);
        cmd(8'h01, 8'h23, 8'h05, 8'h00);
        wrap_up();
    end
endmodule

// File: logic/acx_cmd_exec.sv
// Command executor for accumulator / second-operand arithmetic and
// accumulator-to-parameter copies, fed by nine-byte command frames.
// Assumes one clock, a byte stream with valid/ready and an external
// parameter store that takes a one-cycle write strobe.
module acx_cmd_exec
(
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    // Frame byte stream
    input  wire logic         byte_valid,
    input  wire logic [7:0]   byte_data,
    output logic              byte_ready,
    input  wire logic [7:0]   own_addr,
    input  wire logic         direct_mode,
    // Accumulator load from other commands
    input  wire logic         accu_load,
    input  wire logic [31:0]  accu_load_value,
    // Parameter write strobe
    output logic              par_wr,
    output logic              par_is_global,
    output logic [7:0]        par_index,
    output logic [7:0]        par_bank,
    output logic [31:0]       par_value,
    // Reply
    output logic              reply_valid,
    input  wire logic         reply_ready,
    output logic [7:0]        reply_addr,
    output logic [7:0]        reply_status,
    output logic [7:0]        reply_instr,
    output logic [31:0]       reply_value,
    // Working registers
    output logic [31:0]       accu,
    output logic [31:0]       x_reg
);
    import acx_pkg::*;

    acx_state_t   st_q;
    acx_state_t   st_d;
    logic [3:0]   cnt_q;
    logic [7:0]   addr_q;
    logic [7:0]   instr_q;
    logic [7:0]   type_q;
    logic [7:0]   bank_q;
    logic [7:0]   sum_q;
    logic         mode_q;
    logic [31:0]  accu_q;
    logic [31:0]  x_q;
    logic         par_wr_q;
    logic         par_glb_q;
    logic [31:0]  par_val_q;
    logic [31:0]  alu_res;
    logic         div_done;
    logic [31:0]  div_quot;
    logic [31:0]  div_rem;

    // Frame receive decode
    wire logic take       = byte_valid & byte_ready;
    wire logic last_byte  = cnt_q == ACX_IDX_CSUM;
    wire logic sum_ok     = sum_q == byte_data;                          // [R11]
    wire logic addr_ok    = addr_q == own_addr;
    wire logic known_ins  = (instr_q == ACX_INS_CALC_X) | (instr_q == ACX_INS_AAXP) | (instr_q == ACX_INS_AGLP);
    wire logic frame_go   = take & last_byte & sum_ok & addr_ok & known_ins;

    // Execute decode
    wire logic in_exec    = st_q == ACX_ST_EXEC;
    wire logic is_calc    = in_exec & (instr_q == ACX_INS_CALC_X);
    wire logic is_divop   = (type_q == ACX_OP_DIV) | (type_q == ACX_OP_MOD);
    wire logic div_zero   = x_q == 32'h0000_0000;
    wire logic div_start  = is_calc & is_divop & ~div_zero;
    wire logic div_fin    = (st_q == ACX_ST_DIV) & div_done;
    wire logic is_par     = in_exec & ((instr_q == ACX_INS_AAXP) | (instr_q == ACX_INS_AGLP));
    wire logic x_takes    = is_calc & ((type_q == ACX_OP_LOAD) | (type_q == ACX_OP_SWAP));
    wire logic accu_takes = is_calc & ~is_divop & (type_q <= ACX_OP_NOT | type_q == ACX_OP_SWAP);
    wire logic done_cmd   = (in_exec & ~div_start) | div_fin;

    // Ready only while collecting, so a reply or a division stalls the sender
    assign byte_ready = st_q == ACX_ST_RECV;

    // Operation select on accumulator and second operand
    always_comb
    begin
        case (type_q)
            ACX_OP_ADD:  alu_res = accu_q + x_q;                          // [R2]
            ACX_OP_SUB:  alu_res = accu_q - x_q;                          // [R2]
            ACX_OP_MUL:  alu_res = 32'(accu_q * x_q);                     // [R2]
            ACX_OP_AND:  alu_res = accu_q & x_q;                          // [R3]
            ACX_OP_OR:   alu_res = accu_q | x_q;                          // [R3]
            ACX_OP_XOR:  alu_res = accu_q ^ x_q;                          // [R3]
            ACX_OP_NOT:  alu_res = ~x_q;                                  // [R4]
            ACX_OP_SWAP: alu_res = x_q;                                   // [R6]
            default:     alu_res = accu_q;
        endcase
    end

    // Sequence: collect, execute, optional division, optional reply
    always_comb
    begin
        case (st_q)
            ACX_ST_RECV:  st_d = frame_go ? ACX_ST_EXEC : ACX_ST_RECV;
            ACX_ST_EXEC:  st_d = div_start ? ACX_ST_DIV : (mode_q ? ACX_ST_REPLY : ACX_ST_RECV);
            ACX_ST_DIV:   st_d = div_done ? (mode_q ? ACX_ST_REPLY : ACX_ST_RECV) : ACX_ST_DIV;
            ACX_ST_REPLY: st_d = reply_ready ? ACX_ST_RECV : ACX_ST_REPLY; // [R7]
            default:      st_d = ACX_ST_RECV;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            st_q <= ACX_ST_RECV;
        else
            st_q <= st_d;
    end

    // Frame capture; value bytes are don't-care for these commands
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q   <= 4'h0;
            addr_q  <= 8'h00;
            instr_q <= 8'h00;
            type_q  <= 8'h00;
            bank_q  <= 8'h00;
            sum_q   <= 8'h00;
            mode_q  <= 1'b0;
        end
        else if (take)
        begin
            cnt_q <= last_byte ? 4'h0 : cnt_q + 4'h1;                     // [R10]
            sum_q <= last_byte ? 8'h00 : sum_q + byte_data;               // [R11]
            if (cnt_q == ACX_IDX_ADDR)
                addr_q <= byte_data;                                      // [R10]
            if (cnt_q == ACX_IDX_INSTR)
                instr_q <= byte_data;                                     // [R10]
            if (cnt_q == ACX_IDX_TYPE)
                type_q <= byte_data;                                      // [R10]
            if (cnt_q == ACX_IDX_BANK)
                bank_q <= byte_data;                                      // [R10]
            if (last_byte)
                mode_q <= direct_mode;
        end
    end

    // Accumulator: command results win over an outside load
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            accu_q <= ACX_ACCU_RST;
        else if (accu_takes)
            accu_q <= alu_res;                                            // [R1]
        else if (div_fin)
            accu_q <= (type_q == ACX_OP_DIV) ? div_quot : div_rem;        // [R2]
        else if (accu_load)
            accu_q <= accu_load_value;
    end

    // Second operand register; swap reads the old accumulator this cycle
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            x_q <= ACX_X_RST;
        else if (x_takes)
            x_q <= accu_q;                                                // [R5] [R6]
    end

    // Parameter write strobe carries the accumulator as it stands
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            par_wr_q  <= 1'b0;
            par_glb_q <= 1'b0;
            par_val_q <= 32'h0000_0000;
        end
        else
        begin
            par_wr_q <= is_par;                                           // [R8] [R9]
            if (is_par)
            begin
                par_glb_q <= instr_q == ACX_INS_AGLP;                     // [R9]
                par_val_q <= accu_q;                                      // [R8]
            end
        end
    end

    // Long division in its own unit; zero divisor leaves the accumulator
    acx_divider
    #(
        .W (32)
    )
    u_div
    (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .start    (div_start),
        .dividend (accu_q),
        .divisor  (x_q),
        .done     (div_done),
        .quot     (div_quot),
        .rem      (div_rem)
    );

    // Outputs
    assign par_wr        = par_wr_q;
    assign par_is_global = par_glb_q;
    assign par_index     = type_q;                                        // [R8] [R9]
    assign par_bank      = bank_q;
    assign par_value     = par_val_q;
    assign reply_valid   = st_q == ACX_ST_REPLY;                          // [R7]
    assign reply_addr    = addr_q;
    assign reply_status  = ACX_STATUS_OK;                                 // [R7]
    assign reply_instr   = instr_q;
    assign reply_value   = 32'h0000_0000;
    assign accu          = accu_q;
    assign x_reg         = x_q;

endmodule

// File: logic/acx_divider.sv
// Iterative signed divider, one quotient bit per clock.
// Assumes start is a pulse while idle and divisor is not zero.
module acx_divider
#(
    parameter int W = 32
)
(
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    // Request
    input  wire logic         start,
    input  wire logic [W-1:0] dividend,
    input  wire logic [W-1:0] divisor,
    // Result
    output logic              done,
    output logic [W-1:0]      quot,
    output logic [W-1:0]      rem
);

    localparam int CW = $clog2(W) + 1;

    // Refuse widths the shift loop cannot serve
    if (W < 2)
    begin : g_bad_w
        $error("acx_divider: W must be at least 2");
    end

    logic [W-1:0]  quo_q;
    logic [W-1:0]  rem_q;
    logic [W-1:0]  dvs_q;
    logic [CW-1:0] cnt_q;
    logic          qneg_q;
    logic          rneg_q;
    logic          done_q;

    // One restoring step on magnitudes
    wire logic [W:0]   shifted = {rem_q, quo_q[W-1]};
    wire logic         fits    = shifted >= {1'b0, dvs_q};
    wire logic [W:0]   reduced = shifted - {1'b0, dvs_q};
    wire logic [W-1:0] mag_a   = dividend[W-1] ? W'(-dividend) : dividend;
    wire logic [W-1:0] mag_b   = divisor[W-1] ? W'(-divisor) : divisor;

    // Sequencer; remainder takes the dividend's sign like C
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            quo_q  <= '0;
            rem_q  <= '0;
            dvs_q  <= '0;
            cnt_q  <= '0;
            qneg_q <= 1'b0;
            rneg_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (start)
        begin
            quo_q  <= mag_a;
            rem_q  <= '0;
            dvs_q  <= mag_b;
            cnt_q  <= CW'(W);
            qneg_q <= dividend[W-1] ^ divisor[W-1];
            rneg_q <= dividend[W-1];
            done_q <= 1'b0;
        end
        else if (cnt_q != '0)
        begin
            quo_q  <= {quo_q[W-2:0], fits};
            rem_q  <= fits ? reduced[W-1:0] : shifted[W-1:0];
            cnt_q  <= cnt_q - 1'b1;
            done_q <= (cnt_q == CW'(1));
        end
        else
        begin
            done_q <= 1'b0;
        end
    end

    assign done = done_q;
    assign quot = qneg_q ? W'(-quo_q) : quo_q;
    assign rem  = rneg_q ? W'(-rem_q) : rem_q;

endmodule

// File: logic/acx_pkg.sv
// Constants for the accumulator / second-operand command slice.
// Assumes command frames arrive one byte per handshake on one clock.
// Notes on behaviour
// R1: Instruction 33 combines the accumulator with the second operand register and writes the result to the accumulator.
// R2: For instruction 33, types 0 to 4 are add, subtract operand, multiply, divide by operand and modulo by operand.
// R3: For instruction 33, types 5, 6 and 7 are bitwise AND, OR and XOR of the accumulator with the operand.
// R4: For instruction 33, type 8 yields the bitwise inversion of the second operand register.
// R5: For instruction 33, type 9 copies the accumulator into the second operand register.
// R6: For instruction 33, type 10 exchanges accumulator and second operand register in one step.
// R7: In direct mode each of instructions 33, 34 and 35 is answered with status 100 and a meaningless value.
// R8: Instruction 34 writes the accumulator into the axis parameter named by type for the motor in the bank byte.
// R9: Instruction 35 writes the accumulator into the global parameter named by type within the bank in the bank byte.
// R10: A frame is address, instruction, type, motor/bank, four value bytes most significant first, then checksum.
// R11: The checksum is the low eight bits of the sum of the first eight bytes and mismatching frames are dropped.
package acx_pkg;

    // Frame layout
    localparam logic [3:0]  ACX_IDX_ADDR   = 4'h0;
    localparam logic [3:0]  ACX_IDX_INSTR  = 4'h1;
    localparam logic [3:0]  ACX_IDX_TYPE   = 4'h2;
    localparam logic [3:0]  ACX_IDX_BANK   = 4'h3;
    localparam logic [3:0]  ACX_IDX_CSUM   = 4'h8;

    // Instruction numbers
    localparam logic [7:0]  ACX_INS_CALC_X = 8'h21;
    localparam logic [7:0]  ACX_INS_AAXP   = 8'h22;
    localparam logic [7:0]  ACX_INS_AGLP   = 8'h23;

    // Operation codes carried in the type byte
    localparam logic [7:0]  ACX_OP_ADD     = 8'h00;
    localparam logic [7:0]  ACX_OP_SUB     = 8'h01;
    localparam logic [7:0]  ACX_OP_MUL     = 8'h02;
    localparam logic [7:0]  ACX_OP_DIV     = 8'h03;
    localparam logic [7:0]  ACX_OP_MOD     = 8'h04;
    localparam logic [7:0]  ACX_OP_AND     = 8'h05;
    localparam logic [7:0]  ACX_OP_OR      = 8'h06;
    localparam logic [7:0]  ACX_OP_XOR     = 8'h07;
    localparam logic [7:0]  ACX_OP_NOT     = 8'h08;
    localparam logic [7:0]  ACX_OP_LOAD    = 8'h09;
    localparam logic [7:0]  ACX_OP_SWAP    = 8'h0A;

    // Reply and reset values
    localparam logic [7:0]  ACX_STATUS_OK  = 8'h64;
    localparam logic [31:0] ACX_ACCU_RST   = 32'h0000_0000;
    localparam logic [31:0] ACX_X_RST      = 32'h0000_0000;

    // Executor states, one-hot
    typedef enum logic [3:0] {
        ACX_ST_RECV  = 4'b0001,
        ACX_ST_EXEC  = 4'b0010,
        ACX_ST_DIV   = 4'b0100,
        ACX_ST_REPLY = 4'b1000
    } acx_state_t;

endpackage
